// ==== hdl/sfpid_cfg.svh ====
// Purpose: constants of the serial flash power-down and identification logic
// Assumes: 10 MHz system clock on both ends
// Notes: timing figures not fixed elsewhere are plain defaults
`ifndef SFPID_CFG_SVH
`define SFPID_CFG_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFPID_OP_PD 8'hB9
`define SFPID_OP_WAKE 8'hAB
`define SFPID_OP_ORD 8'h90
`define SFPID_OP_STD 8'h9F

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SFPID_OP_BITS 7'h08
`define SFPID_HEAD_LONG 7'h20
`define SFPID_ADDR_BYTE 3'h3
`define SFPID_DATA_BYTE 3'h4
`define SFPID_STD_LAST 2'h2

// ----------------------------------------------------------------
// timing, in ns and ms, and the derived cycle counts
// ----------------------------------------------------------------
`define SFPID_CLK_NS 100
`define SFPID_TDP_NS 3000
`define SFPID_WAKE_ONLY_DELAY_NS 3000
`define SFPID_WAKE_WITH_ID_DELAY_NS 1800
`define SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MIN_MS 1
`define SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MAX_MS 10
// device side: longest times round down
`define SFPID_TDP_CYC_DEV (`SFPID_TDP_NS / `SFPID_CLK_NS)
`define SFPID_WAKE_ONLY_DELAY_CYC_DEV (`SFPID_WAKE_ONLY_DELAY_NS / `SFPID_CLK_NS)
`define SFPID_WAKE_WITH_ID_DELAY_CYC_DEV (`SFPID_WAKE_WITH_ID_DELAY_NS / `SFPID_CLK_NS)
// host side: least waits round up
`define SFPID_TDP_CYC_HOST ((`SFPID_TDP_NS + `SFPID_CLK_NS - 1) / `SFPID_CLK_NS)
`define SFPID_WAKE_ONLY_DELAY_CYC_HOST ((`SFPID_WAKE_ONLY_DELAY_NS + `SFPID_CLK_NS - 1) / `SFPID_CLK_NS)
`define SFPID_WAKE_WITH_ID_DELAY_CYC_HOST ((`SFPID_WAKE_WITH_ID_DELAY_NS + `SFPID_CLK_NS - 1) / `SFPID_CLK_NS)
`define SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MIN_CYC (`SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MIN_MS * 1000000 / `SFPID_CLK_NS)
`define SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MAX_CYC (`SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MAX_MS * 1000000 / `SFPID_CLK_NS)
`define SFPID_CS_GAP_CYC 1
`define SFPID_SYNC_LAT 3
`define SFPID_BUSY_CYC 64
`define SFPID_HALF_CYC 2

`endif

// ==== hdl/sfpid_dev.sv ====
// Purpose: flash end: power-down entry and release, three ID reads, busy and write lock-out
// Assumes: link logic runs on the serial clock; timers run on clk_in
// Notes: identity bytes are arbitrary parameter values
`timescale 1ns/10ps
`include "sfpid_cfg.svh"

// Behaviour
// - opcode B9h requests deep power-down
// - power-down only if select rises after bit eight
// - powered down within entry delay after select rise
// - while powered down only ABh is honoured
// - reset leaves device in normal operation
// - ABh alone wakes after first wake delay
// - ABh plus three dummies returns device ID
// - legacy ID repeats until select rises
// - ID read from power-down wakes after second delay
// - ABh ignored while busy, cycle unaffected
// - 90h with address 0 returns maker then device
// - address 1 swaps the two ID bytes
// - ordered ID alternates until select rises
// - 9Fh returns maker, memory type, capacity
// - writes refused during power-up lock-out
// - busy set during self-timed cycle, then cleared
module sfpid_dev #(
  parameter int unsigned LOCK_CYC = `SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MIN_CYC,
  parameter int unsigned BUSY_CYC = `SFPID_BUSY_CYC,
  parameter logic [7:0] MFR_ID = 8'hC3,   // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h14,   // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h30, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h15  // arbitrary value
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  sfpid_link_if.flash link,
  input wire logic wr_cycle_start_in,
  output logic powered_down_out,
  output logic busy_out,
  output logic write_ok_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // delay load, shortened by the select synchroniser latency, never below one
  function automatic logic [15:0] cnt_load(input int unsigned cyc);
    if (cyc > `SFPID_SYNC_LAT + 1) begin
      cnt_load = 16'(cyc - `SFPID_SYNC_LAT);
    end else begin
      cnt_load = 16'h0001;
    end
  endfunction : cnt_load

  // identity byte for the current output slot
  function automatic logic [7:0] id_byte(input logic [7:0] op, input logic [1:0] n, input logic lsb);
    if (op == `SFPID_OP_STD) begin
      id_byte = (n == 2'h0) ? MFR_ID : (n == 2'h1) ? MEM_TYPE : CAPACITY;
    end else if (op == `SFPID_OP_ORD) begin
      id_byte = (n[0] ^ lsb) ? DEV_ID : MFR_ID;
    end else begin
      id_byte = DEV_ID;
    end
  endfunction : id_byte

  sfpid_pkg::sfpid_core_s core_q, core_d;
  sfpid_pkg::sfpid_frame_s fr_q, fr_d;
  sfpid_pkg::sfpid_lnk_s lnk_q, lnk_d;
  sfpid_pkg::sfpid_out_s out_q, out_d;
  logic frame_rst;
  logic cs_rise;
  logic [7:0] op_full;
  logic byte_done;
  logic [7:0] id_cur;

  // ----------------------------------------------------------------
  // link side, serial clock domain
  // ----------------------------------------------------------------
  // select high or system reset clears the decoder; the serial clock may stop between frames
  assign frame_rst = link.cs_n | ~arst_n_in;
  assign op_full = {fr_q.sr[6:0], link.mosi};
  assign byte_done = (fr_q.bit_n == 3'h7);

  // shift and decode on rising edges, msb first
  always_comb begin
    fr_d = fr_q;
    fr_d.bit_n = fr_q.bit_n + 3'h1;
    fr_d.sr = op_full;
    if (byte_done) begin
      if (fr_q.byte_n != `SFPID_DATA_BYTE) begin
        fr_d.byte_n = fr_q.byte_n + 3'h1;
      end
      if (fr_q.byte_n == 3'h0) begin
        fr_d.op = op_full;
        // 9Fh answers right after the opcode, never while powered down
        fr_d.data_on = (op_full == `SFPID_OP_STD) && !lnk_q.pd_s2;
      end
      if (fr_q.byte_n == `SFPID_ADDR_BYTE) begin
        fr_d.addr_lsb = op_full[0];
        // dummy values only count time; of the address only bit 0 is kept, to pick the 90h byte order
        if (fr_q.op == `SFPID_OP_ORD && !lnk_q.pd_s2) begin
          fr_d.data_on = 1'b1;
        end
        if (fr_q.op == `SFPID_OP_WAKE && !lnk_q.busy_s2) begin
          fr_d.data_on = 1'b1;
        end
      end
      if (fr_q.data_on) begin
        if (fr_q.op == `SFPID_OP_STD) begin
          fr_d.out_n = (fr_q.out_n == `SFPID_STD_LAST) ? 2'h0 : fr_q.out_n + 2'h1;
        end else begin
          fr_d.out_n = {1'b0, ~fr_q.out_n[0]};
        end
      end
    end
  end

  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      fr_q <= '0;
    end else begin
      fr_q <= fr_d;
    end
  end

  // frame kind survives select high, so the timer side can read it at the select rise
  always_comb begin
    lnk_d = lnk_q;
    lnk_d.pd_s1 = core_q.pd;
    lnk_d.pd_s2 = lnk_q.pd_s1;
    lnk_d.busy_s1 = core_q.busy;
    lnk_d.busy_s2 = lnk_q.busy_s1;
    if (fr_q.bit_n == 3'h0 && fr_q.byte_n == 3'h0) begin
      lnk_d.kind = sfpid_pkg::KIND_NONE;
    end else if (byte_done && fr_q.byte_n == 3'h0) begin
      if (op_full == `SFPID_OP_PD && !lnk_q.pd_s2) begin
        lnk_d.kind = sfpid_pkg::KIND_PD;
      end else if (op_full == `SFPID_OP_WAKE && !lnk_q.busy_s2) begin
        lnk_d.kind = sfpid_pkg::KIND_WAKE1;
      end
    end else if (lnk_q.kind == sfpid_pkg::KIND_PD) begin
      lnk_d.kind = sfpid_pkg::KIND_NONE;
    end else if (lnk_q.kind == sfpid_pkg::KIND_WAKE1) begin
      lnk_d.kind = sfpid_pkg::KIND_WAKE2;
    end
  end

  always_ff @(posedge link.sclk or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // identity byte of the current slot, held in a net so single bits can be picked
  assign id_cur = id_byte(fr_q.op, fr_q.out_n, fr_q.addr_lsb);

  // launch data on falling edges so the host samples it stable on the next fall, one serial period later
  always_comb begin
    out_d.doe = fr_q.data_on;
    out_d.dout = fr_q.data_on & id_cur[~fr_q.bit_n];
  end

  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign link.miso_do = out_q.dout;
  assign link.miso_oe = out_q.doe;

  // ----------------------------------------------------------------
  // timer side, clk_in domain
  // ----------------------------------------------------------------
  assign cs_rise = core_q.cs_s2 & ~core_q.cs_s3;

  always_comb begin
    core_d = core_q;
    core_d.cs_s1 = link.cs_n;
    core_d.cs_s2 = core_q.cs_s1;
    core_d.cs_s3 = core_q.cs_s2;
    core_d.kind_s1 = lnk_q.kind;
    core_d.kind_s2 = core_q.kind_s1;
    if (core_q.tmr != 16'h0000) begin
      core_d.tmr = core_q.tmr - 16'h0001;
    end
    // power state walk
    case (core_q.pwr)
      sfpid_pkg::PWR_ON: begin
        if (cs_rise && core_q.kind_s2 == sfpid_pkg::KIND_PD) begin
          core_d.pwr = sfpid_pkg::PWR_ENTER;
          core_d.tmr = cnt_load(`SFPID_TDP_CYC_DEV);
        end
      end
      sfpid_pkg::PWR_ENTER: begin
        if (core_q.tmr == 16'h0000) begin
          core_d.pwr = sfpid_pkg::PWR_DOWN;
          core_d.pd = 1'b1;
        end
      end
      sfpid_pkg::PWR_DOWN: begin
        if (cs_rise && core_q.kind_s2 == sfpid_pkg::KIND_WAKE1) begin
          core_d.pwr = sfpid_pkg::PWR_WAKE;
          core_d.tmr = cnt_load(`SFPID_WAKE_ONLY_DELAY_CYC_DEV);
        end else if (cs_rise && core_q.kind_s2 == sfpid_pkg::KIND_WAKE2) begin
          core_d.pwr = sfpid_pkg::PWR_WAKE;
          core_d.tmr = cnt_load(`SFPID_WAKE_WITH_ID_DELAY_CYC_DEV);
        end
      end
      sfpid_pkg::PWR_WAKE: begin
        if (core_q.tmr == 16'h0000) begin
          core_d.pwr = sfpid_pkg::PWR_ON;
          core_d.pd = 1'b0;
        end
      end
      default: begin
        core_d.pwr = sfpid_pkg::PWR_ON;
        core_d.pd = 1'b0;
      end
    endcase
    // power-up write lock-out
    if (core_q.lock_cnt != 20'h00000) begin
      core_d.lock_cnt = core_q.lock_cnt - 20'h00001;
    end else begin
      core_d.wr_ok = 1'b1;
    end
    // self-timed cycle; refused during lock-out or power-down
    if (core_q.busy) begin
      if (core_q.busy_cnt == 16'h0000) begin
        core_d.busy = 1'b0;
      end else begin
        core_d.busy_cnt = core_q.busy_cnt - 16'h0001;
      end
    end else if (wr_cycle_start_in && core_q.wr_ok && !core_q.pd) begin
      core_d.busy = 1'b1;
      core_d.busy_cnt = 16'(BUSY_CYC - 1);
    end
  end

  // reset lands in normal operation with writes locked
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, kind_s1: sfpid_pkg::KIND_NONE,
                  kind_s2: sfpid_pkg::KIND_NONE, pwr: sfpid_pkg::PWR_ON, pd: 1'b0,
                  tmr: 16'h0000, busy: 1'b0, busy_cnt: 16'h0000,
                  lock_cnt: 20'(LOCK_CYC), wr_ok: 1'b0};
    end else begin
      core_q <= core_d;
    end
  end

  assign powered_down_out = core_q.pd;
  assign busy_out = core_q.busy;
  assign write_ok_out = core_q.wr_ok;

endmodule : sfpid_dev

// ==== hdl/sfpid_host.sv ====
// Purpose: host controller end: frames power-down, wake and ID read commands
// Assumes: link clock derived from clk_in by a divider
// Notes: mode 0, data out sampled one full serial period after launch
`timescale 1ns/10ps
`include "sfpid_cfg.svh"
module sfpid_host #(
  parameter int unsigned HALF_CYC = `SFPID_HALF_CYC,
  parameter int unsigned LOCK_CYC = `SFPID_POWERUP_WRITE_LOCKOUT_DELAY_MAX_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  sfpid_link_if.host link,
  input wire logic cmd_valid_in,
  input wire sfpid_pkg::sfpid_cmd_e cmd_op_in,
  input wire logic cmd_addr_lsb_in,
  input wire logic [2:0] cmd_nbytes_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_byte_out,
  output logic write_ok_out
);

  sfpid_pkg::sfpid_host_s h_q, h_d;
  logic [7:0] op;
  logic [6:0] head;
  logic [6:0] nbits;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb begin
    op = `SFPID_OP_STD;
    head = `SFPID_OP_BITS;
    nbits = {1'b0, cmd_nbytes_in, 3'h0};
    case (cmd_op_in)
      sfpid_pkg::CMD_PD: begin
        op = `SFPID_OP_PD;
        nbits = 7'h00;
      end
      sfpid_pkg::CMD_WAKE: begin
        op = `SFPID_OP_WAKE;
        nbits = 7'h00;
      end
      sfpid_pkg::CMD_ID_AB: begin
        op = `SFPID_OP_WAKE;
        head = `SFPID_HEAD_LONG;
      end
      sfpid_pkg::CMD_ID_ORD: begin
        op = `SFPID_OP_ORD;
        head = `SFPID_HEAD_LONG;
      end
      default: begin
        op = `SFPID_OP_STD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  always_comb begin
    h_d = h_q;
    h_d.rsp_valid = 1'b0;
    h_d.miso_s1 = link.miso;
    h_d.miso_s2 = h_q.miso_s1;
    if (h_q.lock != 20'h00000) begin
      h_d.lock = h_q.lock - 20'h00001;
    end else begin
      h_d.wr_ok = 1'b1;
    end
    case (h_q.st)
      sfpid_pkg::H_IDLE: begin
        if (cmd_valid_in) begin
          h_d.st = sfpid_pkg::H_SHIFT;
          h_d.ready = 1'b0;
          h_d.cs_n = 1'b0;
          h_d.tx = {op, 23'h000000, cmd_addr_lsb_in & (cmd_op_in == sfpid_pkg::CMD_ID_ORD)};
          h_d.mosi = op[7];
          h_d.head = head;
          h_d.total = head + nbits;
          h_d.pcnt = 7'h00;
          h_d.rxbits = 3'h0;
          h_d.half = 8'(HALF_CYC - 1);
          // select-high wait after the frame, per command
          case (cmd_op_in)
            sfpid_pkg::CMD_PD: h_d.gap_ld = 16'(`SFPID_TDP_CYC_HOST);
            sfpid_pkg::CMD_WAKE: h_d.gap_ld = 16'(`SFPID_WAKE_ONLY_DELAY_CYC_HOST);
            sfpid_pkg::CMD_ID_AB: h_d.gap_ld = 16'(`SFPID_WAKE_WITH_ID_DELAY_CYC_HOST);
            default: h_d.gap_ld = 16'(`SFPID_CS_GAP_CYC);
          endcase
        end
      end
      sfpid_pkg::H_SHIFT: begin
        if (h_q.half != 8'h00) begin
          h_d.half = h_q.half - 8'h01;
        end else begin
          h_d.half = 8'(HALF_CYC - 1);
          if (!h_q.sclk) begin
            h_d.sclk = 1'b1;
            h_d.pcnt = h_q.pcnt + 7'h01;
          end else begin
            h_d.sclk = 1'b0;
            // bit launched by the device one serial period ago
            if (h_q.pcnt > h_q.head) begin
              h_d.rx = {h_q.rx[6:0], h_q.miso_s2};
              h_d.rxbits = h_q.rxbits + 3'h1;
              if (h_q.rxbits == 3'h7) begin
                h_d.rsp_valid = 1'b1;
                h_d.rsp_byte = {h_q.rx[6:0], h_q.miso_s2};
              end
            end
            if (h_q.pcnt == h_q.total) begin
              h_d.cs_n = 1'b1;
              h_d.mosi = 1'b0;
              h_d.st = sfpid_pkg::H_GAP;
              h_d.gap = h_q.gap_ld;
            end else begin
              h_d.tx = {h_q.tx[30:0], 1'b0};
              h_d.mosi = h_q.tx[30];
            end
          end
        end
      end
      sfpid_pkg::H_GAP: begin
        if (h_q.gap != 16'h0000) begin
          h_d.gap = h_q.gap - 16'h0001;
        end else begin
          h_d.st = sfpid_pkg::H_IDLE;
          h_d.ready = 1'b1;
        end
      end
      default: begin
        h_d.st = sfpid_pkg::H_IDLE;
        h_d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      h_q <= '{st: sfpid_pkg::H_IDLE, sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0, half: 8'h00,
               pcnt: 7'h00, head: 7'h00, total: 7'h00, tx: 32'h00000000, rx: 8'h00,
               rxbits: 3'h0, rsp_valid: 1'b0, rsp_byte: 8'h00, gap: 16'h0000,
               gap_ld: 16'h0000, miso_s1: 1'b1, miso_s2: 1'b1,
               lock: 20'(LOCK_CYC), wr_ok: 1'b0, ready: 1'b1};
    end else begin
      h_q <= h_d;
    end
  end

  assign link.sclk = h_q.sclk;
  assign link.cs_n = h_q.cs_n;
  assign link.mosi = h_q.mosi;
  assign cmd_ready_out = h_q.ready;
  assign rsp_valid_out = h_q.rsp_valid;
  assign rsp_byte_out = h_q.rsp_byte;
  assign write_ok_out = h_q.wr_ok;

endmodule : sfpid_host

// ==== hdl/sfpid_link_if.sv ====
// Purpose: serial link between the host controller and the flash end
// Assumes: mode 0 framing, chip select active low
// Notes: data out idles high through a modelled pull-up
`timescale 1ns/10ps
interface sfpid_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_do;
  logic miso_oe;
  logic miso;

  // resolved line level; the pull-up wins when nobody drives
  assign miso = miso_oe ? miso_do : 1'b1;

  modport host (output sclk, output cs_n, output mosi, input miso);
  modport flash (input sclk, input cs_n, input mosi, output miso_do, output miso_oe);
endinterface : sfpid_link_if

// ==== hdl/sfpid_pkg.sv ====
// Purpose: types of the serial flash power-down and identification logic
// Assumes: constants live in sfpid_cfg.svh
// Notes: one state struct per register group; each group sits in one clock domain
package sfpid_pkg;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ON = 2'b00, PWR_ENTER = 2'b01, PWR_DOWN = 2'b10, PWR_WAKE = 2'b11
  } sfpid_pwr_e;

  // one bit changes per step except KIND_WAKE2 back to KIND_NONE, which flips both; a settled value syncs cleanly
  typedef enum logic [1:0] {
    KIND_NONE = 2'b00, KIND_WAKE1 = 2'b01, KIND_WAKE2 = 2'b11, KIND_PD = 2'b10
  } sfpid_kind_e;

  typedef enum logic [2:0] {
    CMD_PD = 3'b000, CMD_WAKE = 3'b001, CMD_ID_AB = 3'b010, CMD_ID_ORD = 3'b011, CMD_ID_STD = 3'b100
  } sfpid_cmd_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_SHIFT = 2'b01, H_GAP = 2'b10
  } sfpid_hst_e;

  // ----------------------------------------------------------------
  // state structs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_s1; logic cs_s2; logic cs_s3;
    sfpid_kind_e kind_s1; sfpid_kind_e kind_s2;
    sfpid_pwr_e pwr; logic pd; logic [15:0] tmr;
    logic busy; logic [15:0] busy_cnt;
    logic [19:0] lock_cnt; logic wr_ok;
  } sfpid_core_s;

  typedef struct packed {
    logic [2:0] bit_n; logic [2:0] byte_n; logic [7:0] sr; logic [7:0] op;
    logic addr_lsb; logic [1:0] out_n; logic data_on;
  } sfpid_frame_s;

  typedef struct packed {
    sfpid_kind_e kind; logic pd_s1; logic pd_s2; logic busy_s1; logic busy_s2;
  } sfpid_lnk_s;

  typedef struct packed {
    logic dout; logic doe;
  } sfpid_out_s;

  typedef struct packed {
    sfpid_hst_e st; logic sclk; logic cs_n; logic mosi; logic [7:0] half;
    logic [6:0] pcnt; logic [6:0] head; logic [6:0] total; logic [31:0] tx;
    logic [7:0] rx; logic [2:0] rxbits; logic rsp_valid; logic [7:0] rsp_byte;
    logic [15:0] gap; logic [15:0] gap_ld; logic miso_s1; logic miso_s2;
    logic [19:0] lock; logic wr_ok; logic ready;
  } sfpid_host_s;

endpackage : sfpid_pkg

// ==== verification/sfpid_properties.sv ====
// Purpose: link checks between the host and flash ends
// Assumes: every link signal but miso is a register of clk_in or of sclk; miso is decoded from miso_oe and miso_do
// Notes: frame opcode and bit count are rebuilt from the wire
`timescale 1ns/10ps
`include "sfpid_cfg.svh"
module sfpid_properties (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_do,
  input wire logic miso_oe,
  input wire logic miso
);
  // ------------------------------------------------------------
  // frame tracker and properties
  // ------------------------------------------------------------
  typedef struct packed {logic sclk; logic [7:0] op; logic [5:0] nb;} sfpid_chk_s;
  sfpid_chk_s chk_q, chk_d;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // opcode and rising-edge count of the open frame, cleared while deselected
  always_comb begin
    chk_d = chk_q;
    chk_d.sclk = sclk;
    if (cs_n) begin
      chk_d.op = 8'h00;
      chk_d.nb = 6'h00;
    end else if (sclk && !chk_q.sclk) begin
      if (chk_q.nb < 6'h08) chk_d.op = {chk_q.op[6:0], mosi};
      if (chk_q.nb != 6'h3F) chk_d.nb = chk_q.nb + 6'h01; // saturates: long reads need no exact count
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) chk_q <= '0;
    else chk_q <= chk_d;
  end

  idle_release_a: assert property (cs_n |-> !miso_oe && miso)
    else $error("data out driven while deselected");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data moved while serial clock high");
  out_fall_a: assert property ($rose(miso_oe) |-> $fell(sclk))
    else $error("data out enabled off a falling edge");
  shift_fall_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_do) |-> $fell(sclk))
    else $error("data out bit moved off a falling edge");
  out_start_a: assert property ($rose(miso_oe) |-> chk_q.nb == (chk_q.op == `SFPID_OP_STD ? 6'h08 : 6'h20))
    else $error("identifier began after a wrong bit count");
  pd_len_a: assert property ($rose(cs_n) && chk_q.op == `SFPID_OP_PD |-> chk_q.nb == 6'h08)
    else $error("power-down frame not closed after eight bits");
  select_gap_a: assert property ($rose(cs_n) && (chk_q.op == `SFPID_OP_PD || chk_q.op == `SFPID_OP_WAKE)
    |-> cs_n [*8])
    else $error("select dropped too soon after a power frame");
  frame_bound_a: assert property ($fell(cs_n) |-> ##[1:600] cs_n)
    else $error("frame never closed");

  cover property ($rose(miso_oe));
  cover property ($rose(cs_n) && chk_q.op == `SFPID_OP_PD);
  cover property ($rose(cs_n) && chk_q.op == `SFPID_OP_WAKE && chk_q.nb > 6'h20);
endmodule : sfpid_properties

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench joining host and flash ends
// Assumes: both ends share clk_in; lock-out shortened to 20 cycles
// Notes: expected ID bytes are queued before each command
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------------------------
  // setup
  // ------------------------------------------------------------
  localparam int LOCK_C = 20;
  localparam int BUSY_C = 400; // outlasts a whole legacy ID frame
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DID = 8'h21; // arbitrary value
  localparam logic [7:0] MTY = 8'h40; // arbitrary value
  localparam logic [7:0] CAP = 8'h16; // arbitrary value
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b1;
  logic cmd_valid = 1'b0;
  sfpid_pkg::sfpid_cmd_e cmd_op = sfpid_pkg::CMD_PD;
  logic cmd_lsb = 1'b0;
  logic [2:0] cmd_n = 3'h0;
  logic wr_start = 1'b0;
  logic ready, rsp_valid, h_wr_ok, pd, busy, d_wr_ok;
  logic [7:0] rsp_byte;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int n_checks = 0;
  int seed = 16;

  sfpid_link_if lnk ();
  sfpid_host #(.LOCK_CYC(LOCK_C)) sfpid_host_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_addr_lsb_in(cmd_lsb), .cmd_nbytes_in(cmd_n),
    .cmd_ready_out(ready), .rsp_valid_out(rsp_valid), .rsp_byte_out(rsp_byte), .write_ok_out(h_wr_ok));
  sfpid_dev #(.LOCK_CYC(LOCK_C), .BUSY_CYC(BUSY_C), .MFR_ID(MFR), .DEV_ID(DID), .MEM_TYPE(MTY), .CAPACITY(CAP))
    sfpid_dev_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(lnk), .wr_cycle_start_in(wr_start),
    .powered_down_out(pd), .busy_out(busy), .write_ok_out(d_wr_ok));
  sfpid_properties sfpid_properties_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso_do(lnk.miso_do), .miso_oe(lnk.miso_oe), .miso(lnk.miso));

  always #50 clk_in = ~clk_in;

  task automatic chkb(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : chkb

  task automatic chkf(input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : chkf

  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic pulse();
    @(posedge clk_in);
    wr_start <= 1'b1;
    @(posedge clk_in);
    wr_start <= 1'b0;
  endtask : pulse

  // queue the answer the rules predict, issue the command, wait for idle
  task automatic run(input sfpid_pkg::sfpid_cmd_e op, input logic lsb, input logic [2:0] n, input logic quiet);
    int i;
    // an ignored command leaves the line at its pull-up level, so the host reads all ones
    for (i = 0; i < n; i++) begin
      case (quiet ? sfpid_pkg::CMD_PD : op)
        sfpid_pkg::CMD_PD: exp_q.push_back(8'hFF);
        sfpid_pkg::CMD_ID_STD: exp_q.push_back(i % 3 == 0 ? MFR : (i % 3 == 1 ? MTY : CAP));
        sfpid_pkg::CMD_ID_ORD: exp_q.push_back((i % 2) == lsb ? MFR : DID);
        default: exp_q.push_back(DID);
      endcase
    end
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_lsb <= lsb;
    cmd_n <= n;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    i = 0;
    @(posedge clk_in);
    while (ready !== 1'b1 && i < 2000) begin
      @(posedge clk_in);
      i++;
    end
    chkf(1'b1, ready);
    chkf(1'b1, exp_q.size() == 0);
  endtask : run

  // every answer byte is matched against the oldest note
  always @(posedge clk_in) begin
    if (rsp_valid === 1'b1) begin
      chkb(exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, rsp_byte);
    end
  end

  // watchdog: the whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    summarize();
  end

  initial begin
    int k, n, r;
    arst_n_in <= 1'b0; // a real falling edge, so every asynchronous reset branch runs
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    pulse();
    @(negedge clk_in);
    chkf(1'b0, busy);
    chkf(1'b0, pd);
    repeat (LOCK_C + 5) @(posedge clk_in);
    chkf(1'b1, d_wr_ok);
    chkf(1'b1, h_wr_ok);
    run(sfpid_pkg::CMD_ID_STD, 1'b0, 3'h4, 1'b0);
    for (k = 0; k < 2; k++) begin
      r = $random(seed);
      run(sfpid_pkg::CMD_ID_ORD, k[0], 3'h2 + 3'(r[1:0]), 1'b0);
    end
    run(sfpid_pkg::CMD_ID_AB, 1'b0, 3'h3, 1'b0);
    // power-down refuses 9Fh and 90h reads until a bare wake
    run(sfpid_pkg::CMD_PD, 1'b0, 3'h0, 1'b1);
    @(negedge clk_in);
    chkf(1'b1, pd);
    run(sfpid_pkg::CMD_ID_STD, 1'b0, 3'h2, 1'b1);
    run(sfpid_pkg::CMD_ID_ORD, 1'b0, 3'h2, 1'b1);
    chkf(1'b1, pd);
    run(sfpid_pkg::CMD_WAKE, 1'b0, 3'h0, 1'b1);
    @(negedge clk_in);
    chkf(1'b0, pd);
    // wake through a legacy ID read
    run(sfpid_pkg::CMD_PD, 1'b0, 3'h0, 1'b1);
    run(sfpid_pkg::CMD_ID_AB, 1'b0, 3'h1, 1'b0);
    @(negedge clk_in);
    chkf(1'b0, pd);
    // a legacy ID read during a write cycle gets no answer and no effect
    pulse();
    fork
      begin
        n = 0;
        @(negedge clk_in);
        while (busy === 1'b1 && n < 1000) begin
          @(negedge clk_in);
          n++;
        end
      end
      run(sfpid_pkg::CMD_ID_AB, 1'b0, 3'h1, 1'b1);
    join
    chkf(1'b1, n == BUSY_C);
    run(sfpid_pkg::CMD_ID_STD, 1'b0, 3'h1, 1'b0);
    summarize();
  end
endmodule : tb_top
